// >>> cdfo_pkg.sv
// Package of register map, field positions and types for the driver control bank
package cdfo_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h01;
    localparam logic [7:0] ADDR_MASK = 8'h02;
    localparam logic [7:0] ADDR_POLARITY = 8'h03;
    localparam logic [7:0] ADDR_OUT0_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_OUT0_CTRL = 8'h05;
    localparam logic [7:0] ADDR_OUT1_LEVEL = 8'h06;
    localparam logic [7:0] ADDR_OUT1_CTRL = 8'h07;

    // Reset values
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_POLARITY = 8'hc0;
    localparam logic [7:0] RST_OUT0_LEVEL = 8'h90;
    localparam logic [7:0] RST_OUT0_CTRL = 8'h02;
    localparam logic [7:0] RST_OUT1_LEVEL = 8'h90;
    localparam logic [7:0] RST_OUT1_CTRL = 8'hda;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Status register fields
    localparam int STAT_SIG_PRESENT = 0;
    localparam int STAT_TERM_LSB = 1;
    localparam int STAT_TERM_MSB = 4;

    // Mask register fields
    localparam int MASK_SIG = 0;
    localparam int MASK_TERM_LSB = 1;
    localparam int MASK_TERM_MSB = 4;
    localparam int MASK_OUT0_OFF = 5;
    localparam int MASK_OUT1_OFF = 6;
    localparam int MASK_RATE_SEL = 7;

    // Polarity register fields
    localparam int POL_SIG = 0;
    localparam int POL_TERM_LSB = 1;
    localparam int POL_TERM_MSB = 4;
    localparam int POL_SLOW_THR0_LOW = 6;
    localparam int POL_FAST_THR0_LOW = 7;

    // Level registers
    localparam int LVL_SWING_LSB = 0;
    localparam int LVL_SWING_MSB = 4;
    localparam int LVL_FAST_UP_LSB = 5;
    localparam int LVL_FAST_UP_MSB = 7;

    // Control registers
    localparam int CTL_SLOW_UP_LSB = 0;
    localparam int CTL_SLOW_UP_MSB = 2;
    localparam int CTL0_MUTE_SEL = 3;
    localparam int CTL0_ABSENT_PD_LINK = 4;
    localparam int CTL0_FORCE_PRESENT = 5;
    localparam int CTL0_FORCE_ABSENT = 6;
    localparam int CTL1_SLOW_THR1_LOW = 6;
    localparam int CTL1_FAST_THR1_LOW = 7;

    // Serial management port
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        SM_IDLE = 3'b000,
        SM_ADDR = 3'b001,
        SM_ADDR_ACK = 3'b010,
        SM_WR_BYTE = 3'b011,
        SM_WR_ACK = 3'b100,
        SM_RD_BYTE = 3'b101,
        SM_RD_ACK = 3'b110
    } cdfo_sm_state_t;

    // Controls handed to the analog driver stages
    typedef struct packed {
        logic mute;
        logic add_offset;
        logic out1_power_off;
        logic out0_power_off;
        logic rate_sd;
        logic [3:0] thr1;
        logic [3:0] thr0;
        logic [4:0] out1_swing_level;
        logic [4:0] out0_swing_level;
    } cdfo_analog_t;

endpackage : cdfo_pkg

// >>> cdfo_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module cdfo_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;
    logic [W-1:0] level_next;

    // Take the new value only when stages two and three agree
    assign level_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (level_reg & (s2_reg ^ s3_reg));
    assign o_level = level_reg;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            level_reg <= RST_VAL;
        end else begin
            s1_reg <= i_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end
endmodule : cdfo_sync

// >>> cdfo_top.sv
// Control register bank with serial management slave for a dual-output cable driver
// Behaviour
// RULE_01: Output 0 fast threshold is level reg bits 7:5 plus polarity bit 7.
// RULE_02: Output 0 slow threshold is ctrl bits 2:0 plus polarity bit 6.
// RULE_03: Output 1 fast threshold is level reg bits 7:5 plus ctrl bit 7.
// RULE_04: Output 1 slow threshold is ctrl bits 2:0 plus ctrl bit 6.
// RULE_05: Rate selection 0 applies fast threshold, 1 applies slow threshold.
// RULE_06: Termination polarity 0 faults on flag high, 1 faults on flag low.
// RULE_07: Signal polarity 0 faults on signal absent, 1 on signal present.
// RULE_08: A set mask bit keeps its condition off the fault pin.
// RULE_09: Absent signal adds offset when mute select is 0, mutes when 1.
// RULE_10: Force-absent applies mute or offset regardless of input signal.
// RULE_11: Force-present never mutes or offsets the output.
// RULE_12: Status always reports the true input signal presence.
// RULE_13: Link bit clear: power-down from power-off bits and enable pin only.
// RULE_14: Link bit set: absent signal also powers both drivers down.
// RULE_15: Each output has a five-bit swing level, reset 10000.
// RULE_16: Host writes 011 into output 1 control bits 5:3.
// RULE_17: Host writes 0 into polarity bit 5 and output 0 control bit 7.
// RULE_18: Rate pin high forces slow rate, else register bit selects.
// RULE_19: Signal status bit reads 1 when signal present, 0 when absent.
// RULE_20: All fields reset to defaults; fault pin combines unmasked conditions, active low.
`timescale 1ns/1ns
module cdfo_top import cdfo_pkg::*; #(
    // Arbitrary bus address of the slave
    parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire logic i_enable,
    input wire logic i_rate_select_pin,
    input wire logic i_input_signal_present,
    input wire logic [3:0] i_term_fault,
    output logic o_fault_n,
    output cdfo_analog_t o_analog
);
    logic scl;
    logic sda;
    logic enable;
    logic rate_pin;
    logic sig_present;
    logic [3:0] term_fault;

    cdfo_sync #(.W(2), .RST_VAL(2'h3)) u_sync_bus (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_scl, i_sda}),
        .o_level({scl, sda})
    );

    cdfo_sync #(.W(7), .RST_VAL(7'h00)) u_sync_pins (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_enable, i_rate_select_pin, i_input_signal_present, i_term_fault}),
        .o_level({enable, rate_pin, sig_present, term_fault})
    );

    // Bus line events
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise = scl & ~scl_prev_reg;
    assign scl_fall = ~scl & scl_prev_reg;
    assign bus_start = scl & scl_prev_reg & sda_prev_reg & ~sda;
    assign bus_stop = scl & scl_prev_reg & ~sda_prev_reg & sda;

    // Serial slave state
    cdfo_sm_state_t state_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] ptr_reg;
    logic have_cmd_reg;
    logic sda_low_reg;
    logic wr_en_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic [7:0] rd_data;
    logic [7:0] shift_in;
    logic addr_match;

    assign shift_in = {shift_reg[6:0], sda};
    assign addr_match = (shift_reg[7:1] == SLAVE_ADDR);
    assign o_sda = 1'b0;
    assign o_sda_oe = sda_low_reg;

    // Registers
    logic [7:0] mask_reg;
    logic [7:0] pol_reg;
    logic [7:0] lvl0_reg;
    logic [7:0] ctl0_reg;
    logic [7:0] lvl1_reg;
    logic [7:0] ctl1_reg;
    logic [7:0] status_val;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl;
            sda_prev_reg <= sda;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg <= SM_IDLE;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            ptr_reg <= 8'h00;
            have_cmd_reg <= 1'b0;
            sda_low_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
        end else begin
            wr_en_reg <= 1'b0;
            if (bus_stop) begin
                state_reg <= SM_IDLE;
                sda_low_reg <= 1'b0;
            end else if (bus_start) begin
                state_reg <= SM_ADDR;
                bit_cnt_reg <= 4'h0;
                have_cmd_reg <= 1'b0;
                sda_low_reg <= 1'b0;
            end else begin
                case (state_reg)
                    SM_ADDR, SM_WR_BYTE: begin
                        if (scl_rise) begin
                            shift_reg <= shift_in;
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
                            bit_cnt_reg <= 4'h0;
                            if (state_reg == SM_ADDR) begin
                                state_reg <= addr_match ? SM_ADDR_ACK : SM_IDLE;
                                sda_low_reg <= addr_match;
                            end else begin
                                state_reg <= SM_WR_ACK;
                                sda_low_reg <= 1'b1;
                                if (!have_cmd_reg) begin
                                    ptr_reg <= shift_reg;
                                    have_cmd_reg <= 1'b1;
                                end else begin
                                    wr_en_reg <= 1'b1;
                                    wr_addr_reg <= ptr_reg;
                                    wr_data_reg <= shift_reg;
                                    ptr_reg <= ptr_reg + 8'h01;
                                end
                            end
                        end
                    end
                    SM_ADDR_ACK, SM_RD_ACK: begin
                        if (state_reg == SM_RD_ACK && scl_rise && sda) begin
                            state_reg <= SM_IDLE;
                        end else if (scl_fall && state_reg == SM_ADDR_ACK && !shift_reg[0]) begin
                            state_reg <= SM_WR_BYTE;
                            sda_low_reg <= 1'b0;
                        end else if (scl_fall) begin
                            // Load next read byte and drive its first bit
                            state_reg <= SM_RD_BYTE;
                            sda_low_reg <= ~rd_data[7];
                            tx_reg <= {rd_data[6:0], 1'b0};
                            bit_cnt_reg <= 4'h1;
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                    end
                    SM_WR_ACK: begin
                        if (scl_fall) begin
                            state_reg <= SM_WR_BYTE;
                            sda_low_reg <= 1'b0;
                        end
                    end
                    SM_RD_BYTE: begin
                        if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
                            state_reg <= SM_RD_ACK;
                            sda_low_reg <= 1'b0;
                        end else if (scl_fall) begin
                            sda_low_reg <= ~tx_reg[7];
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                    end
                    default: begin
                        sda_low_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // RULE_20 Reset defaults
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mask_reg <= RST_MASK;
            pol_reg <= RST_POLARITY;
            lvl0_reg <= RST_OUT0_LEVEL;
            ctl0_reg <= RST_OUT0_CTRL;
            lvl1_reg <= RST_OUT1_LEVEL;
            ctl1_reg <= RST_OUT1_CTRL;
        end else if (wr_en_reg) begin
            if (wr_addr_reg == ADDR_MASK) begin
                mask_reg <= wr_data_reg;
            end else if (wr_addr_reg == ADDR_POLARITY) begin
                pol_reg <= wr_data_reg;
            end else if (wr_addr_reg == ADDR_OUT0_LEVEL) begin
                lvl0_reg <= wr_data_reg;
            end else if (wr_addr_reg == ADDR_OUT0_CTRL) begin
                ctl0_reg <= wr_data_reg;
            end else if (wr_addr_reg == ADDR_OUT1_LEVEL) begin
                lvl1_reg <= wr_data_reg;
            end else if (wr_addr_reg == ADDR_OUT1_CTRL) begin
                ctl1_reg <= wr_data_reg;
            end
        end
    end

    // RULE_12 True signal state in status
    // RULE_19 Present reads one
    assign status_val = {3'h0, term_fault, sig_present};

    always_comb begin
        if (ptr_reg == ADDR_STATUS) begin
            rd_data = status_val;
        end else if (ptr_reg == ADDR_MASK) begin
            rd_data = mask_reg;
        end else if (ptr_reg == ADDR_POLARITY) begin
            rd_data = pol_reg;
        end else if (ptr_reg == ADDR_OUT0_LEVEL) begin
            rd_data = lvl0_reg;
        end else if (ptr_reg == ADDR_OUT0_CTRL) begin
            rd_data = ctl0_reg;
        end else if (ptr_reg == ADDR_OUT1_LEVEL) begin
            rd_data = lvl1_reg;
        end else if (ptr_reg == ADDR_OUT1_CTRL) begin
            rd_data = ctl1_reg;
        end else begin
            rd_data = UNMAPPED_READ;
        end
    end

    // Thresholds
    logic [3:0] fast_thr0;
    logic [3:0] slow_thr0;
    logic [3:0] fast_thr1;
    logic [3:0] slow_thr1;
    logic rate_sd;

    // RULE_01 Fast threshold output 0
    assign fast_thr0 = {lvl0_reg[LVL_FAST_UP_MSB:LVL_FAST_UP_LSB], pol_reg[POL_FAST_THR0_LOW]};
    // RULE_02 Slow threshold output 0
    assign slow_thr0 = {ctl0_reg[CTL_SLOW_UP_MSB:CTL_SLOW_UP_LSB], pol_reg[POL_SLOW_THR0_LOW]};
    // RULE_03 Fast threshold output 1
    assign fast_thr1 = {lvl1_reg[LVL_FAST_UP_MSB:LVL_FAST_UP_LSB], ctl1_reg[CTL1_FAST_THR1_LOW]};
    // RULE_04 Slow threshold output 1
    assign slow_thr1 = {ctl1_reg[CTL_SLOW_UP_MSB:CTL_SLOW_UP_LSB], ctl1_reg[CTL1_SLOW_THR1_LOW]};
    // RULE_18 Pin overrides rate bit
    assign rate_sd = rate_pin | mask_reg[MASK_RATE_SEL];

    // Fault pin
    logic [3:0] term_cond;
    logic sig_cond;
    logic fault_n_next;

    // RULE_06 Termination polarity
    // RULE_08 Masked conditions drop out
    assign term_cond = (term_fault ^ pol_reg[POL_TERM_MSB:POL_TERM_LSB])
        & ~mask_reg[MASK_TERM_MSB:MASK_TERM_LSB];
    // RULE_07 Signal polarity
    assign sig_cond = ~(sig_present ^ pol_reg[POL_SIG]) & ~mask_reg[MASK_SIG];
    // RULE_20 Active-low combination
    assign fault_n_next = ~(|term_cond | sig_cond);

    // Signal-loss handling
    logic absent_eff;
    logic link_off;
    cdfo_analog_t analog_next;

    // RULE_11 Force present wins
    // RULE_10 Force absent holds action
    assign absent_eff = ctl0_reg[CTL0_FORCE_PRESENT] ? 1'b0
        : (ctl0_reg[CTL0_FORCE_ABSENT] | ~sig_present);
    // RULE_13 Link clear ignores signal
    // RULE_14 Link set adds absence
    assign link_off = ~enable | (ctl0_reg[CTL0_ABSENT_PD_LINK] & ~sig_present);

    always_comb begin
        // RULE_09 Mute or offset select
        analog_next.mute = absent_eff & ctl0_reg[CTL0_MUTE_SEL];
        analog_next.add_offset = absent_eff & ~ctl0_reg[CTL0_MUTE_SEL];
        analog_next.out1_power_off = link_off | mask_reg[MASK_OUT1_OFF];
        analog_next.out0_power_off = link_off | mask_reg[MASK_OUT0_OFF];
        analog_next.rate_sd = rate_sd;
        // RULE_05 Threshold by rate
        analog_next.thr1 = rate_sd ? slow_thr1 : fast_thr1;
        analog_next.thr0 = rate_sd ? slow_thr0 : fast_thr0;
        // RULE_15 Swing level fields
        analog_next.out1_swing_level = lvl1_reg[LVL_SWING_MSB:LVL_SWING_LSB];
        analog_next.out0_swing_level = lvl0_reg[LVL_SWING_MSB:LVL_SWING_LSB];
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_fault_n <= 1'b1;
            o_analog <= '0;
        end else begin
            o_fault_n <= fault_n_next;
            o_analog <= analog_next;
        end
    end
endmodule : cdfo_top

// >>> cdfo_chk.sv
// Port-level assertions for the driver control bank
`timescale 1ns/1ns
module cdfo_chk import cdfo_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda,
    input wire logic o_sda_oe,
    input wire logic i_enable,
    input wire logic i_rate_select_pin,
    input wire logic i_input_signal_present,
    input wire logic [3:0] i_term_fault,
    input wire logic o_fault_n,
    input wire cdfo_analog_t o_analog
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    sequence s_defaults;
        o_analog.out0_swing_level == 5'h10 && o_analog.out1_swing_level == 5'h10
            && o_analog.thr0 == (o_analog.rate_sd ? 4'h5 : 4'h9)
            && o_analog.thr1 == (o_analog.rate_sd ? 4'h5 : 4'h9);
    endsequence
    sequence s_still;
        i_scl && $stable({i_enable, i_rate_select_pin, i_input_signal_present, i_term_fault});
    endsequence
    sequence s_quiet;
        s_still[*8] ##1 s_still[*4];
    endsequence
    sequence s_rate_high;
        i_rate_select_pin[*8] ##1 i_rate_select_pin[*4];
    endsequence
    sequence s_enable_low;
        (!i_enable)[*8] ##1 (!i_enable)[*4];
    endsequence
    sequence s_both_off;
        o_analog.out0_power_off && o_analog.out1_power_off;
    endsequence

    AST_RESET_VALUES: assert property ($fell(i_sys_rst) |-> o_fault_n && o_analog == '0)
        else $error("outputs not at reset level after reset");
    AST_DEFAULTS: assert property ($fell(i_sys_rst) |-> ##[1:8] s_defaults)
        else $error("swing or threshold defaults missing after reset");
    AST_RATE_PIN: assert property (s_rate_high |=> o_analog.rate_sd)
        else $error("rate pin high did not force slow rate");
    AST_ENABLE_LOW: assert property (s_enable_low |=> s_both_off)
        else $error("enable low did not power both drivers down");
    AST_MUTE_EXCL: assert property (!(o_analog.mute && o_analog.add_offset))
        else $error("mute and offset both active");
    AST_QUIET: assert property (s_quiet |=> $stable(o_analog) && $stable(o_fault_n))
        else $error("outputs moved with inputs and bus quiet");
    AST_ACK_ON_LOW: assert property ($rose(o_sda_oe) |-> !i_scl)
        else $error("data line pulled while bus clock high");
    AST_SDA_ZERO: assert property (o_sda == 1'b0)
        else $error("open-drain data value not low");
endmodule : cdfo_chk

bind cdfo_top cdfo_chk u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_scl(i_scl),
    .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_enable(i_enable),
    .i_rate_select_pin(i_rate_select_pin), .i_input_signal_present(i_input_signal_present),
    .i_term_fault(i_term_fault), .o_fault_n(o_fault_n), .o_analog(o_analog));

// >>> cdfo_host.sv
// Management-bus host model with pulled-up open-drain data line
`timescale 1ns/1ns
module cdfo_host #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire logic i_mclk,
    input wire logic i_dev_sda_oe,
    output logic o_scl,
    output logic o_sda
);
    logic pull_low = 1'b0;
    initial o_scl = 1'b1;
    // Line low when either party pulls
    assign o_sda = ~(pull_low | i_dev_sda_oe);

    task automatic bit_io(input logic b, output logic r);
        @(posedge i_mclk);
        pull_low <= ~b;
        repeat (7) @(posedge i_mclk);
        o_scl <= 1'b1;
        repeat (4) @(posedge i_mclk);
        r = o_sda;
        repeat (3) @(posedge i_mclk);
        o_scl <= 1'b0;
    endtask : bit_io

    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--) bit_io(d[i], q[i]);
    endtask : xfer

    task automatic start();
        @(posedge i_mclk);
        pull_low <= 1'b0;
        repeat (8) @(posedge i_mclk);
        o_scl <= 1'b1;
        repeat (8) @(posedge i_mclk);
        pull_low <= 1'b1;
        repeat (8) @(posedge i_mclk);
        o_scl <= 1'b0;
    endtask : start

    task automatic stop();
        @(posedge i_mclk);
        pull_low <= 1'b1;
        repeat (8) @(posedge i_mclk);
        o_scl <= 1'b1;
        repeat (8) @(posedge i_mclk);
        pull_low <= 1'b0;
        repeat (8) @(posedge i_mclk);
    endtask : stop

    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [7:0] v,
                      output logic ok);
        logic [8:0] q0, q1, q2;
        v = d;
        if (a == 8'h07) v[5:3] = 3'b011;
        if (a == 8'h03) v[5] = 1'b0;
        if (a == 8'h05) v[7] = 1'b0;
        start();
        xfer({ADDR, 1'b0, 1'b1}, q0);
        xfer({a, 1'b1}, q1);
        xfer({v, 1'b1}, q2);
        stop();
        ok = !q0[0] && !q1[0] && !q2[0];
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic [8:0] q0, q1, q2, q3;
        start();
        xfer({ADDR, 1'b0, 1'b1}, q0);
        xfer({a, 1'b1}, q1);
        start();
        xfer({ADDR, 1'b1, 1'b1}, q2);
        xfer(9'h1ff, q3);
        stop();
        d = q3[8:1];
        ok = !q0[0] && !q1[0] && !q2[0];
    endtask : rd

    // Address phase only, to see whether a slave answers
    task automatic probe(input logic [6:0] dev, output logic ack);
        logic [8:0] q;
        start();
        xfer({dev, 1'b0, 1'b1}, q);
        stop();
        ack = !q[0];
    endtask : probe
endmodule : cdfo_host

// >>> cdfo_tb_top.sv
// Self-checking bench for the driver control bank
`timescale 1ns/1ns
module cdfo_tb_top import cdfo_pkg::*;;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0;
    logic rate_pin = 1'b0;
    logic sig = 1'b0;
    logic [3:0] tf = 4'h0;
    logic scl, sda, sda_val, sda_oe, fault_n;
    cdfo_analog_t analog;
    logic [7:0] sh [0:7];
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;

    always #50 mclk = ~mclk;

    cdfo_host #(.ADDR(7'h2a)) host (.i_mclk(mclk), .i_dev_sda_oe(sda_oe), .o_scl(scl),
        .o_sda(sda));
    cdfo_top #(.SLAVE_ADDR(7'h2a)) uut (.i_mclk(mclk), .i_sys_rst(rst), .i_scl(scl),
        .i_sda(sda), .o_sda(sda_val), .o_sda_oe(sda_oe), .i_enable(en),
        .i_rate_select_pin(rate_pin), .i_input_signal_present(sig), .i_term_fault(tf),
        .o_fault_n(fault_n), .o_analog(analog));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.rd(a, d, ok);
        chk("read ack", 32'h1, {31'b0, ok});
        chk($sformatf("reg %h", a), {24'b0, exp}, {24'b0, d});
    endtask : rd_chk

    function automatic logic [23:0] expect_out();
        cdfo_analog_t a;
        logic absent, fault;
        a.rate_sd = rate_pin | sh[2][7];
        a.thr0 = a.rate_sd ? {sh[5][2:0], sh[3][6]} : {sh[4][7:5], sh[3][7]};
        a.thr1 = a.rate_sd ? {sh[7][2:0], sh[7][6]} : {sh[6][7:5], sh[7][7]};
        absent = sh[5][5] ? 1'b0 : (sh[5][6] | ~sig);
        a.mute = absent & sh[5][3];
        a.add_offset = absent & ~sh[5][3];
        a.out0_power_off = ~en | (sh[5][4] & ~sig) | sh[2][5];
        a.out1_power_off = ~en | (sh[5][4] & ~sig) | sh[2][6];
        a.out0_swing_level = sh[4][4:0];
        a.out1_swing_level = sh[6][4:0];
        fault = |((tf ^ sh[3][4:1]) & ~sh[2][4:1]) | (~(sig ^ sh[3][0]) & ~sh[2][0]);
        return {~fault, a};
    endfunction : expect_out

    task automatic pins_chk();
        logic [23:0] e;
        logic [23:0] g;
        e = expect_out();
        g = {fault_n, analog};
        chk("fault pin", 32'(e[23]), 32'(g[23]));
        chk("mute offset", 32'(e[22:21]), 32'(g[22:21]));
        chk("power off", 32'(e[20:19]), 32'(g[20:19]));
        chk("rate thresholds", 32'(e[18:10]), 32'(g[18:10]));
        chk("swing levels", 32'(e[9:0]), 32'(g[9:0]));
    endtask : pins_chk

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 70000) begin
            fails = fails + 1;
            $display("BAD run time expected below 70000 seen %0d", cycles);
            report_and_stop();
        end
    end

    initial begin
        logic [7:0] a, d, s;
        logic ok;
        void'($urandom(32'h70c9d15c));
        sh = '{8'h00, 8'h00, 8'h00, 8'hc0, 8'h90, 8'h02, 8'h90, 8'hda};
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        for (int r = 2; r < 8; r++) rd_chk(8'(r), sh[r]);
        rd_chk(8'h0a, 8'h00);
        $display("test reset_values done");
        host.wr(8'h01, 8'hff, s, ok);
        rd_chk(8'h01, 8'h00);
        $display("test status_write done");
        for (int i = 0; i < 24; i++) begin
            a = (i < 16) ? 8'h05 : 8'(2 + $urandom % 6);
            d = 8'($urandom);
            if (i < 16) d[6:3] = 4'(i);
            host.wr(a, d, s, ok);
            sh[a[2:0]] = s;
            chk("write ack", 32'h1, {31'b0, ok});
            {en, rate_pin, sig, tf} <= 7'($urandom);
            repeat (12) @(posedge mclk);
            pins_chk();
            rd_chk(a, s);
            rd_chk(8'h01, {3'b000, tf, sig});
        end
        $display("test random_config done");
        host.probe(7'h2b, ok);
        chk("foreign address ack", 32'h0, {31'b0, ok});
        rd_chk(8'h02, sh[2]);
        $display("test foreign_address done");
        // Reset again in mid-run: fields back to defaults
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        sh = '{8'h00, 8'h00, 8'h00, 8'hc0, 8'h90, 8'h02, 8'h90, 8'hda};
        pins_chk();
        for (int r = 2; r < 8; r++) rd_chk(8'(r), sh[r]);
        $display("test mid_reset done");
        report_and_stop();
    end
endmodule : cdfo_tb_top
